// >>> hw/arm_delay_pkg.sv
// Package with constants and carrier types for the arming qualifier
package arm_delay_pkg;

  // Clock rate and derived timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int DELAY_MIN_NS     = 200;
  localparam int DELAY_STEP_NS    = 100;
  localparam real DELAY_MAX_S     = 1.67;
  localparam int ARM_SETUP_NS     = 5;
  localparam int EVT_ARM_NS       = 40;
  localparam int EVT_FIRST_NS     = 22;
  localparam int EXPIRY_LATE_NS   = 40;
  localparam int DEAD_MIN_US      = 3000;

  // Cycles per 100 ns delay step (rounded down for a longest figure)
  localparam int STEP_CYC         = DELAY_STEP_NS / CLK_PERIOD_NS;
  // Least setting in steps
  localparam int DELAY_MIN_STEPS  = DELAY_MIN_NS / DELAY_STEP_NS;
  // Largest setting in steps, 1.67 s / 100 ns
  localparam int DELAY_MAX_STEPS  = 16700000;
  // Armed-after-last-event latency in cycles, must stay within 40 ns
  localparam int EVT_ARM_CYC      = (EVT_ARM_NS / CLK_PERIOD_NS) < 1 ? 1 : EVT_ARM_NS / CLK_PERIOD_NS;
  // Least process-plus-display interval, rounded up
  localparam int DEAD_MIN_CYC     = (DEAD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Field widths
  localparam int DELAY_W          = 25;
  localparam int EVT_W            = 24;
  localparam int MTIME_W          = 32;
  localparam int STEP_W           = 3;

  // Limits of the time and event settings
  localparam logic [EVT_W-1:0]   EVT_MIN        = 24'h000002;
  localparam logic [EVT_W-1:0]   EVT_MAX        = 24'hFFFFFF;
  localparam logic [DELAY_W-1:0] DELAY_MIN      = 25'(DELAY_MIN_STEPS);
  localparam logic [DELAY_W-1:0] DELAY_MAX      = 25'(DELAY_MAX_STEPS);

  // Kind of arming delay
  typedef enum logic [1:0] {
    DLY_NONE  = 2'b00,
    DLY_TIME  = 2'b01,
    DLY_EVENT = 2'b10
  } delay_mode_t;

  // Setup of one arming path (start or stop)
  typedef struct packed {
    logic                enable;
    logic                falling;
    delay_mode_t         mode;
    logic [DELAY_W-1:0]  time_steps;
    logic [EVT_W-1:0]    events;
  } arm_cfg_t;

  // Trigger inputs from the channel comparators
  typedef struct packed {
    logic start_trig;
    logic stop_trig;
    logic b_event;
  } trig_in_t;

endpackage : arm_delay_pkg

// >>> hw/arm_qualifier.sv
// One arming path: edge detect, time or event delay, armed flag
`timescale 1ns/10ps
module arm_qualifier
  import arm_delay_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  arm_delay_pkg::arm_cfg_t    cfg,
  input  wire logic                  arm_level,
  input  wire logic                  b_event,
  input  wire logic                  clear,
  output logic                       armed
);

  typedef enum logic [1:0] {
    Q_IDLE  = 2'b00,
    Q_TIME  = 2'b01,
    Q_EVENT = 2'b10,
    Q_ARMED = 2'b11
  } qstate_t;

  qstate_t             state;
  qstate_t             next_state;
  logic                arm_prev;
  logic [DELAY_W-1:0]  steps;
  logic [DELAY_W-1:0]  next_steps;
  logic [STEP_W-1:0]   sub;
  logic [STEP_W-1:0]   next_sub;
  logic [EVT_W-1:0]    evts;
  logic [EVT_W-1:0]    next_evts;
  logic                act_edge;
  logic [DELAY_W-1:0]  tset;
  logic [EVT_W-1:0]    eset;

  // Selected polarity of the arming edge
  assign act_edge = cfg.falling ? (arm_prev & ~arm_level) : (~arm_prev & arm_level);
  // Clamp settings into their legal ranges rather than misbehave
  assign tset = (cfg.time_steps < DELAY_MIN) ? DELAY_MIN :
                (cfg.time_steps > DELAY_MAX) ? DELAY_MAX : cfg.time_steps;
  assign eset = (cfg.events < EVT_MIN) ? EVT_MIN : cfg.events;

  // Next state of the arming sequence
  always_comb begin
    next_state = state;
    next_steps = steps;
    next_sub   = sub;
    next_evts  = evts;
    unique case (state)
      Q_IDLE: begin
        if (cfg.enable && act_edge) begin
          unique case (cfg.mode)
            DLY_TIME: begin
              next_state = Q_TIME;
              next_steps = tset - 25'h0000001;
              next_sub   = 3'(STEP_CYC - 1);
            end
            DLY_EVENT: begin
              next_state = Q_EVENT;
              next_evts  = eset;
            end
            default: next_state = Q_ARMED;
          endcase
        end
      end
      Q_TIME: begin
        // One step per STEP_CYC cycles, armed at expiry
        if (sub != 3'h0) begin
          next_sub = sub - 3'h1;
        end else if (steps == 25'h0000000) begin
          next_state = Q_ARMED;
        end else begin
          next_steps = steps - 25'h0000001;
          next_sub   = 3'(STEP_CYC - 1);
        end
      end
      Q_EVENT: begin
        // Events seen from the cycle after the edge count
        if (b_event) begin
          next_evts = evts - 24'h000001;
          if (evts == 24'h000001) begin
            next_state = Q_ARMED;
          end
        end
      end
      Q_ARMED: next_state = Q_ARMED;
    endcase
    if (clear || !cfg.enable) begin
      next_state = Q_IDLE;
      next_steps = '0;
      next_sub   = '0;
      next_evts  = '0;
    end
  end

  // Register the sequence
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= Q_IDLE;
      arm_prev <= 1'b0;
      steps    <= '0;
      sub      <= '0;
      evts     <= '0;
      armed    <= 1'b0;
    end else begin
      state    <= next_state;
      arm_prev <= arm_level;
      steps    <= next_steps;
      sub      <= next_sub;
      evts     <= next_evts;
      armed    <= (next_state == Q_ARMED);
    end
  end

endmodule : arm_qualifier

// >>> hw/measurement_arming_delay.sv
// Top of the arming qualifier: start/stop arming, gate and dead time
// Summary of operation
// - Start and stop arming may be delayed
// - Time delay 200 ns to 1.67 s, 100 ns steps
// - Armed at the first clock after the arming edge, up to 25 ns later
// - Trigger near delay expiry accepted within window
// - Armed about 40 ns after last event
// - Events after 22 ns count as first
// - Event delay minimum setting is two
// - Measurement time sets gap, not measurement length
// - Unarmed: wait, then start on next trigger
// - Start arming on falling edge supported
// - Time delay from edge, then next trigger starts
// - Gate monitor follows real measurement gate
// - Start arming suspends free run per measurement
// - Arming edge selectable rising or falling
// - Event delay counts B events, max 2^24-1
// - Start plus stop arming gives external gate
`timescale 1ns/10ps
module measurement_arming_delay
  import arm_delay_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  arm_delay_pkg::arm_cfg_t    start_cfg,
  input  arm_delay_pkg::arm_cfg_t    stop_cfg,
  input  arm_delay_pkg::trig_in_t    trig,
  input  wire logic                  arm_in,
  input  wire logic [MTIME_W-1:0]    meas_time,
  input  wire logic                  meas_done,
  output logic                       gate,
  output logic                       gate_monitor,
  output logic                       start_armed,
  output logic                       stop_armed,
  output logic                       waiting
);

  typedef enum logic [1:0] {
    M_WAIT = 2'b00,
    M_RUN  = 2'b01,
    M_DEAD = 2'b10
  } mstate_t;

  mstate_t              state;
  mstate_t              next_state;
  logic [MTIME_W-1:0]   dead;
  logic [MTIME_W-1:0]   next_dead;
  logic                 next_gate;
  logic                 clr;
  logic                 sa;
  logic                 so;
  logic [MTIME_W-1:0]   dead_len;
  logic                 go;
  logic                 stop_now;

  // Start path qualifier
  arm_qualifier u_start (
    .clock     (clock),
    .rst_n     (rst_n),
    .cfg       (start_cfg),
    .arm_level (arm_in),
    .b_event   (trig.b_event),
    .clear     (clr),
    .armed     (sa)
  );

  // Stop path qualifier
  arm_qualifier u_stop (
    .clock     (clock),
    .rst_n     (rst_n),
    .cfg       (stop_cfg),
    .arm_level (arm_in),
    .b_event   (trig.b_event),
    .clear     (clr),
    .armed     (so)
  );

  // Clear both arming paths when a measurement ends
  assign clr = (state == M_RUN) && stop_now;

  // Start when unarmed, or when the start path is armed
  assign go = trig.start_trig && (!start_cfg.enable || sa);
  // Stop on done; with stop arming, only after stop path arms
  assign stop_now = stop_cfg.enable ? (so && (trig.stop_trig || meas_done)) : meas_done;
  // Dead time is the set measurement time, never below the floor
  assign dead_len = (meas_time < MTIME_W'(DEAD_MIN_CYC)) ? MTIME_W'(DEAD_MIN_CYC) : meas_time;

  // Measurement sequencing
  always_comb begin
    next_state = state;
    next_dead  = dead;
    next_gate  = gate;
    unique case (state)
      M_WAIT: begin
        if (go) begin
          next_state = M_RUN;
          next_gate  = 1'b1;
        end
      end
      M_RUN: begin
        if (stop_now) begin
          next_state = M_DEAD;
          next_gate  = 1'b0;
          next_dead  = dead_len;
        end
      end
      M_DEAD: begin
        // Process plus display interval before the next wait
        if (dead <= 32'h00000001) begin
          next_state = M_WAIT;
          next_dead  = '0;
        end else begin
          next_dead = dead - 32'h00000001;
        end
      end
      default: begin
        next_state = M_WAIT;
        next_gate  = 1'b0;
      end
    endcase
  end

  // Registers; all outputs come from flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state        <= M_WAIT;
      dead         <= '0;
      gate         <= 1'b0;
      gate_monitor <= 1'b0;
      start_armed  <= 1'b0;
      stop_armed   <= 1'b0;
      waiting      <= 1'b1;
    end else begin
      state        <= next_state;
      dead         <= next_dead;
      gate         <= next_gate;
      gate_monitor <= next_gate;
      start_armed  <= sa;
      stop_armed   <= so;
      waiting      <= (next_state == M_WAIT);
    end
  end

endmodule : measurement_arming_delay

// >>> verif/arm_delay_props.sv
// Port checker for the arming qualifier
`timescale 1ns/10ps
module arm_delay_props
  import arm_delay_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst_n,
  input arm_delay_pkg::arm_cfg_t start_cfg,
  input arm_delay_pkg::arm_cfg_t stop_cfg,
  input arm_delay_pkg::trig_in_t trig,
  input wire logic               arm_in,
  input wire logic               meas_done,
  input wire logic               gate,
  input wire logic               gate_monitor,
  input wire logic               start_armed,
  input wire logic               stop_armed,
  input wire logic               waiting
);
  logic [17:0] dead_cnt;
  logic [17:0] next_dead_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Cycles since the gate closed; idle once waiting again
  always_comb begin
    next_dead_cnt = dead_cnt;
    if (gate) next_dead_cnt = 18'h1;
    else if (waiting) next_dead_cnt = 18'h0;
    else if (dead_cnt != 18'h0) next_dead_cnt = dead_cnt + 18'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) dead_cnt <= 18'h0;
    else dead_cnt <= next_dead_cnt;
  end
  // Qualifying undelayed edge seen while idle
  sequence start_edge;
    start_cfg.enable && start_cfg.mode == DLY_NONE && waiting && !start_armed &&
      (start_cfg.falling ? $fell(arm_in) : $rose(arm_in));
  endsequence
  a_edge_arms: assert property (start_edge |-> ##2 start_armed) else $error("no arm after edge");
  a_gate_cause: assert property ($rose(gate) |-> $past(trig.start_trig) && $past(waiting))
    else $error("gate without trigger");
  a_gate_armed: assert property ($rose(gate) && start_cfg.enable |-> start_armed) else $error("gate unarmed");
  a_unarmed_start: assert property (waiting && !start_cfg.enable && trig.start_trig |=> gate)
    else $error("free run start lost");
  a_armed_start: assert property (waiting && start_cfg.enable && start_armed && trig.start_trig |=> gate)
    else $error("armed start lost");
  a_done_stops: assert property (gate && meas_done && !stop_cfg.enable |=> !gate) else $error("gate overran");
  a_stop_clears: assert property ($fell(gate) |-> ##1 !start_armed && !stop_armed) else $error("arm kept");
  a_dead_hold: assert property (dead_cnt != 18'h0 && dead_cnt < DEAD_MIN_CYC - 2 |-> !waiting)
    else $error("dead time short");
  a_monitor_on: assert property ($rose(gate) |-> ##[0:1] gate_monitor) else $error("monitor missed");
  a_monitor_real: assert property (gate_monitor |-> gate || $past(gate)) else $error("monitor idle pulse");
endmodule : arm_delay_props

bind measurement_arming_delay arm_delay_props arm_delay_props_i (.clock(clock), .rst_n(rst_n),
  .start_cfg(start_cfg), .stop_cfg(stop_cfg), .trig(trig), .arm_in(arm_in), .meas_done(meas_done), .gate(gate),
  .gate_monitor(gate_monitor), .start_armed(start_armed), .stop_armed(stop_armed), .waiting(waiting));

// >>> verif/sync_source.sv
// Model of the sync source and the measured channel comparators
`timescale 1ns/10ps
module sync_source
  import arm_delay_pkg::*;
(
  input  wire logic               clock,
  output logic                    arm_in,
  output arm_delay_pkg::trig_in_t trig
);
  initial begin
    arm_in = 1'h0;
    trig   = 3'h0;
  end
  // Sync level change, then a cycle of lead before any pulse
  task automatic sync(input logic lvl);
    @(negedge clock) arm_in = lvl;
    @(negedge clock);
  endtask : sync
  // One-cycle comparator event; lines return low after it
  task automatic pulse(input trig_in_t t);
    @(negedge clock) trig = t;
    @(negedge clock) trig = 3'h0;
  endtask : pulse
endmodule : sync_source

// >>> verif/measurement_arming_delay_tb.sv
// Self-checking testbench for the arming qualifier
`timescale 1ns/10ps
module measurement_arming_delay_tb;
  import arm_delay_pkg::*;
  logic        clock;
  logic        rst_n;
  arm_cfg_t    start_cfg;
  arm_cfg_t    stop_cfg;
  trig_in_t    trig;
  logic        arm_in;
  logic [31:0] meas_time;
  logic        meas_done;
  logic        gate;
  logic        gate_monitor;
  logic        start_armed;
  logic        stop_armed;
  logic        waiting;
  int          mismatches;
  int          tests_run;
  int          cycles;
  int          eff;
  measurement_arming_delay measurement_arming_delay_i (.clock(clock), .rst_n(rst_n), .start_cfg(start_cfg),
    .stop_cfg(stop_cfg), .trig(trig), .arm_in(arm_in), .meas_time(meas_time), .meas_done(meas_done), .gate(gate),
    .gate_monitor(gate_monitor), .start_armed(start_armed), .stop_armed(stop_armed), .waiting(waiting));
  sync_source sync_source_i (.clock(clock), .arm_in(arm_in), .trig(trig));
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard; the whole run needs well under this
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic check(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  task automatic gate_is(input logic exp);
    @(negedge clock) check(gate, exp);
  endtask : gate_is
  function automatic arm_cfg_t mk(input logic en, input logic fall, input delay_mode_t m, input int n);
    return '{en, fall, m, 25'(n), 24'(n)};
  endfunction : mk
  // Reset also brings the sync line low, so no stray edge at release
  task automatic restart(input arm_cfg_t s, input arm_cfg_t t);
    rst_n = 1'h0;
    start_cfg = s;
    stop_cfg = t;
    sync_source_i.sync(1'h0);
    repeat (4) @(negedge clock);
    rst_n = 1'h1;
  endtask : restart
  task automatic done();
    @(negedge clock) meas_done = 1'h1;
    @(negedge clock) meas_done = 1'h0;
  endtask : done
  initial begin
    meas_done = 1'h0;
    meas_time = 32'h0;
    // Free run: first trigger starts, dead time blocks the next
    restart(mk(1'h0, 1'h0, DLY_NONE, 0), mk(1'h0, 1'h0, DLY_NONE, 0));
    sync_source_i.pulse(3'h7);
    gate_is(1'h1);
    check(gate_monitor, 1'h1);
    // A set time below the floor must not shorten the gap
    meas_time = 32'h00000020;
    done();
    gate_is(1'h0);
    repeat (40) @(negedge clock);
    sync_source_i.pulse(3'h7);
    gate_is(1'h0);
    check(waiting, 1'h0);
    // Both edge polarities, no delay
    for (int f = 0; f < 2; f++) begin
      restart(mk(1'h1, 1'(f), DLY_NONE, 0), mk(1'h0, 1'h0, DLY_NONE, 0));
      sync_source_i.pulse(3'h4);
      gate_is(1'h0);
      check(waiting, 1'h1);
      sync_source_i.sync(1'h1);
      sync_source_i.pulse(3'h4);
      gate_is(1'(f == 0));
      check(start_armed, 1'(f == 0));
      if (f == 1) begin
        sync_source_i.sync(1'h0);
        sync_source_i.pulse(3'h4);
        gate_is(1'h1);
      end
    end
    // Time delay: early trigger refused, late one starts; one step clamps to two
    for (int i = 0; i < 2; i++) begin
      eff = (i == 0) ? 2 : 4;
      restart(mk(1'h1, 1'h0, DLY_TIME, i == 0 ? 1 : 4), mk(1'h0, 1'h0, DLY_NONE, 0));
      sync_source_i.sync(1'h1);
      repeat (eff * 4 - 7) @(negedge clock);
      sync_source_i.pulse(3'h4);
      gate_is(1'h0);
      repeat (4) @(negedge clock);
      sync_source_i.pulse(3'h4);
      gate_is(1'h1);
    end
    // Event delay: one short of the count refuses, the last event arms
    for (int ev = 1; ev < 4; ev++) begin
      eff = (ev < 2) ? 2 : ev;
      restart(mk(1'h1, 1'h0, DLY_EVENT, ev), mk(1'h0, 1'h0, DLY_NONE, 0));
      sync_source_i.sync(1'h1);
      repeat (eff - 1) sync_source_i.pulse(3'h1);
      sync_source_i.pulse(3'h4);
      gate_is(1'h0);
      sync_source_i.pulse(3'h1);
      sync_source_i.pulse(3'h4);
      gate_is(1'h1);
    end
    // Stop arming delayed by two B events holds the gate open
    restart(mk(1'h1, 1'h0, DLY_NONE, 0), mk(1'h1, 1'h0, DLY_EVENT, 2));
    sync_source_i.sync(1'h1);
    sync_source_i.pulse(3'h4);
    gate_is(1'h1);
    sync_source_i.pulse(3'h1);
    done();
    gate_is(1'h1);
    sync_source_i.pulse(3'h1);
    @(negedge clock) check(stop_armed, 1'h1);
    sync_source_i.pulse(3'h2);
    gate_is(1'h0);
    check(stop_armed, 1'h0);
    check(start_armed, 1'h0);
    // External gate: done ignored until the falling edge arms the stop
    restart(mk(1'h1, 1'h0, DLY_NONE, 0), mk(1'h1, 1'h1, DLY_NONE, 0));
    sync_source_i.sync(1'h1);
    sync_source_i.pulse(3'h4);
    gate_is(1'h1);
    done();
    gate_is(1'h1);
    sync_source_i.sync(1'h0);
    sync_source_i.pulse(3'h2);
    gate_is(1'h0);
    test_done();
  end
endmodule : measurement_arming_delay_tb
